// ==== design/fmc_top.sv ====
// Control core of the fiber modem: rate, timing, carrier, loops, pattern test.
// Pins are asynchronous and resynchronised; registers sit on APB.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module fmc_top
  import fmc_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_KHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        term_txd,
  input  wire logic        term_req,
  input  wire logic        term_ext_clk,
  input  wire logic        term_local_loop,
  input  wire logic        term_remote_loop,
  input  wire logic        line_rxd,
  input  wire logic        line_rx_clk,
  input  wire logic        btn_local_loop,
  input  wire logic        btn_remote_loop,
  input  wire logic        pattern_test_button,
  output logic             line_txd,
  output logic             tx_light,
  output logic             term_rxd,
  output logic             term_tx_clk,
  output logic             term_rx_clk,
  output logic             led_test,
  output logic             led_error,
  output logic             irq
);
  fmc_prbs_if pif ();

  logic [PIN_W-1:0]  pins_s, pins_p, rose;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [INT_W-1:0]  stat_q, stat_d, mask_q, mask_d, ev;
  logic [15:0]       errcnt_q, errcnt_d;
  logic [31:0]       prdata_d, rd_word;
  logic              pready_d, pslverr_d, mapped, apb_wr, irq_d;
  logic [16:0]       nco_q, nco_d;
  logic [17:0]       nco_sum;
  logic              int_clk_q, int_clk_d, half_tick;
  logic              tx_tick, tx_clk_lvl, tx_tick_q;
  logic              rx_tick, rx_bit;
  logic              ll_btn_q, ll_btn_d, rl_btn_q, rl_btn_d, pat_q, pat_d;
  logic              lloop_q, lloop_d, rl_req;
  fmc_rloop_e        rl_q, rl_d;
  logic [9:0]        code_cnt_q, code_cnt_d, ones_q, ones_d, zeros_q, zeros_d;
  logic              far_q, far_d, sync_p_q;
  logic [9:0]        quiet_q, quiet_d;
  logic [24:0]       blink_cnt_q, blink_cnt_d;
  logic              blink_q, blink_d;
  logic              txd_d, light_d, rxd_d, txclk_d, rxclk_d, ltest_d, lerr_d;
  fmc_clksrc_e       src;
  logic [3:0]        rate;
  logic              tx_light_mode_fr, delay_en, ll_en, rl_en, x21;

  assign rate     = ctrl_q[CTRL_RATE_LSB +: 4];
  assign src      = fmc_clksrc_e'(ctrl_q[CTRL_SRC_LSB +: 2]);
  assign tx_light_mode_fr  = ctrl_q[CTRL_TX_LIGHT_MODE_FR];
  assign delay_en = ctrl_q[CTRL_DELAY];
  assign ll_en    = ctrl_q[CTRL_LL_EN];
  assign rl_en    = ctrl_q[CTRL_RL_EN];
  assign x21      = ctrl_q[CTRL_X21];

  fmc_sync #(.W(PIN_W)) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({pattern_test_button, btn_remote_loop, btn_local_loop, line_rx_clk,
                line_rxd, term_remote_loop, term_local_loop, term_ext_clk,
                term_req, term_txd}),
    .sync_out (pins_s)
  );

  fmc_prbs u_prbs (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pif     (pif.prbs)
  );

  assign rose = pins_s & ~pins_p;

  // Bit timing and receive path
  always_comb begin
    nco_sum   = {1'b0, nco_q} + 18'({rate_kbps(rate), 1'b0});
    nco_d     = nco_sum[16:0];
    half_tick = 1'b0;
    if (nco_sum >= 18'(CLK_KHZ)) begin
      nco_d     = 17'(nco_sum - 18'(CLK_KHZ));
      half_tick = 1'b1;
    end
    int_clk_d = int_clk_q ^ half_tick;
    case (src)
      SRC_EXT: begin
        tx_tick    = rose[PIN_EXTCLK];
        tx_clk_lvl = pins_s[PIN_EXTCLK];
      end
      SRC_RCV: begin
        tx_tick    = rose[PIN_RXCLK];
        tx_clk_lvl = pins_s[PIN_RXCLK];
      end
      default: begin
        tx_tick    = half_tick & ~int_clk_q;
        tx_clk_lvl = int_clk_q;
      end
    endcase
    if (lloop_q) begin
      rx_tick = tx_tick_q;
      rx_bit  = line_txd;
    end else begin
      rx_tick = rose[PIN_RXCLK];
      rx_bit  = pins_s[PIN_RXD];
    end
  end

  // Buttons, loop requests and remote loop sequencer
  always_comb begin
    ll_btn_d   = ll_btn_q ^ rose[PIN_BTN_LL];
    rl_btn_d   = rl_btn_q ^ rose[PIN_BTN_RL];
    pat_d      = pat_q ^ rose[PIN_PAT];
    lloop_d    = ll_btn_q | (ll_en & pins_s[PIN_LL]);
    rl_req     = rl_btn_q | (rl_en & pins_s[PIN_RL]);
    rl_d       = rl_q;
    code_cnt_d = code_cnt_q;
    case (rl_q)
      RL_IDLE: begin
        code_cnt_d = '0;
        if (rl_req) begin
          rl_d = RL_SEND;
        end
      end
      RL_SEND: begin
        if (!rl_req) begin
          rl_d = RL_IDLE;
        end else if (tx_tick) begin
          code_cnt_d = code_cnt_q + 10'h001;
          if (code_cnt_q == LOOP_CODE_BITS - 10'h001) begin
            rl_d = RL_ACTIVE;
          end
        end
      end
      RL_ACTIVE: begin
        if (!rl_req) begin
          rl_d = RL_IDLE;
        end
      end
      default: rl_d = RL_IDLE;
    endcase
    ones_d  = ones_q;
    zeros_d = zeros_q;
    far_d   = far_q;
    if (lloop_q || rl_q != RL_IDLE) begin
      ones_d  = '0;
      zeros_d = '0;
      far_d   = 1'b0;
    end else if (rx_tick) begin
      ones_d  = rx_bit ? ((ones_q == LOOP_DET_BITS) ? ones_q : ones_q + 10'h001) : '0;
      zeros_d = rx_bit ? '0 : ((zeros_q == LOOP_DET_BITS) ? zeros_q : zeros_q + 10'h001);
      if (ones_d == LOOP_DET_BITS) begin
        far_d = 1'b1;
      end else if (zeros_d == LOOP_DET_BITS) begin
        far_d = 1'b0;
      end
    end
  end

  // Line and terminal outputs, indicators
  always_comb begin
    txd_d = line_txd;
    if (far_q) begin
      if (rx_tick) begin
        txd_d = rx_bit;
      end
    end else if (tx_tick) begin
      if (rl_q == RL_SEND) begin
        txd_d = 1'b1;
      end else if (pat_q) begin
        txd_d = pif.tx_bit;
      end else begin
        txd_d = pins_s[PIN_TXD];
      end
    end
    light_d = tx_light_mode_fr ? pins_s[PIN_REQ] : 1'b1;
    rxd_d   = term_rxd;
    if (rx_tick) begin
      rxd_d = (delay_en && ones_q >= LOOP_DELAY_BITS) ? 1'b0 : rx_bit;
    end
    txclk_d = tx_clk_lvl;
    rxclk_d = x21 ? 1'b0 : (lloop_q ? tx_clk_lvl : pins_s[PIN_RXCLK]);
    ltest_d = lloop_q | (rl_q != RL_IDLE) | far_q | pat_q;
    quiet_d = quiet_q;
    if (!pat_q) begin
      quiet_d = ERR_QUIET_BITS;
    end else if (pif.err) begin
      quiet_d = '0;
    end else if (rx_tick && quiet_q != ERR_QUIET_BITS) begin
      quiet_d = quiet_q + 10'h001;
    end
    blink_cnt_d = blink_cnt_q + 25'h000_0001;
    blink_d     = blink_q;
    if (blink_cnt_q == 25'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_d = '0;
      blink_d     = ~blink_q;
    end
    lerr_d = pat_q && (quiet_q < ERR_STEADY_BITS || (quiet_q < ERR_QUIET_BITS && blink_q));
  end

  // Register file and interrupts
  always_comb begin
    mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) || (paddr == ADDR_INT_STAT) ||
             (paddr == ADDR_INT_MASK) || (paddr == ADDR_ERR_CNT);
    apb_wr = psel & penable & pready & pwrite;
    case (paddr)
      ADDR_CTRL:     rd_word = 32'(ctrl_q);
      ADDR_STAT:     rd_word = {24'h00_0000, tx_light, led_error, pif.in_sync, pat_q, far_q,
                                (rl_q == RL_ACTIVE), (rl_q == RL_SEND), lloop_q};
      ADDR_INT_STAT: rd_word = 32'(stat_q);
      ADDR_INT_MASK: rd_word = 32'(mask_q);
      ADDR_ERR_CNT:  rd_word = {16'h0000, errcnt_q};
      default:       rd_word = 32'h0000_0000;
    endcase
    pready_d  = psel & ~penable;
    pslverr_d = psel & ~penable & ~mapped;
    prdata_d  = (psel & ~penable & ~pwrite) ? rd_word : prdata;
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_d = pwdata[CTRL_W-1:0];
    end
    if (apb_wr && paddr == ADDR_INT_MASK) begin
      mask_d = pwdata[INT_W-1:0];
    end
    ev               = '0;
    ev[INT_ERR]      = pif.err;
    ev[INT_SYNC]     = pif.in_sync & ~sync_p_q;
    ev[INT_FAR_LOOP] = far_d ^ far_q;
    ev[INT_RL_UP]    = (rl_d == RL_ACTIVE) && (rl_q != RL_ACTIVE);
    stat_d = stat_q;
    if (apb_wr && paddr == ADDR_INT_STAT) begin
      stat_d = stat_q & ~pwdata[INT_W-1:0];
    end
    stat_d   = stat_d | ev;
    irq_d    = |(stat_q & mask_q);
    errcnt_d = errcnt_q;
    if (rose[PIN_PAT] && !pat_q) begin
      errcnt_d = '0;
    end else if (pif.err && errcnt_q != 16'hffff) begin
      errcnt_d = errcnt_q + 16'h0001;
    end
  end

  assign pif.run     = pat_q;
  assign pif.tx_tick = tx_tick;
  assign pif.rx_tick = rx_tick;
  assign pif.rx_bit  = rx_bit;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pins_p      <= '0;
      nco_q       <= '0;
      int_clk_q   <= 1'b0;
      tx_tick_q   <= 1'b0;
      ll_btn_q    <= 1'b0;
      rl_btn_q    <= 1'b0;
      pat_q       <= 1'b0;
      lloop_q     <= 1'b0;
      rl_q        <= RL_IDLE;
      code_cnt_q  <= '0;
      ones_q      <= '0;
      zeros_q     <= '0;
      far_q       <= 1'b0;
      sync_p_q    <= 1'b0;
      quiet_q     <= ERR_QUIET_BITS;
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
      line_txd    <= 1'b0;
      tx_light    <= 1'b1;
      term_rxd    <= 1'b0;
      term_tx_clk <= 1'b0;
      term_rx_clk <= 1'b0;
      led_test    <= 1'b0;
      led_error   <= 1'b0;
      ctrl_q      <= CTRL_RESET;
      mask_q      <= '0;
      stat_q      <= '0;
      errcnt_q    <= '0;
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
    end else begin
      pins_p      <= pins_s;
      nco_q       <= nco_d;
      int_clk_q   <= int_clk_d;
      tx_tick_q   <= tx_tick;
      ll_btn_q    <= ll_btn_d;
      rl_btn_q    <= rl_btn_d;
      pat_q       <= pat_d;
      lloop_q     <= lloop_d;
      rl_q        <= rl_d;
      code_cnt_q  <= code_cnt_d;
      ones_q      <= ones_d;
      zeros_q     <= zeros_d;
      far_q       <= far_d;
      sync_p_q    <= pif.in_sync;
      quiet_q     <= quiet_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
      line_txd    <= txd_d;
      tx_light    <= light_d;
      term_rxd    <= rxd_d;
      term_tx_clk <= txclk_d;
      term_rx_clk <= rxclk_d;
      led_test    <= ltest_d;
      led_error   <= lerr_d;
      ctrl_q      <= ctrl_d;
      mask_q      <= mask_d;
      stat_q      <= stat_d;
      errcnt_q    <= errcnt_d;
      prdata      <= prdata_d;
      pready      <= pready_d;
      pslverr     <= pslverr_d;
      irq         <= irq_d;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_rate_default;
    $rose(rstn) |-> (rate == RATE_DEFAULT) && (src == SRC_INT) && !tx_light_mode_fr;
  endproperty
  a_rate_default: assert property (p_rate_default) else $error("bad reset config");

  property p_carrier_on;
    !tx_light_mode_fr ##1 !tx_light_mode_fr |-> tx_light;
  endproperty
  a_carrier_on: assert property (p_carrier_on) else $error("carrier dropped");

  property p_carrier_req;
    tx_light_mode_fr && !pins_s[PIN_REQ] |=> !tx_light;
  endproperty
  a_carrier_req: assert property (p_carrier_req) else $error("carrier without request");

  property p_x21_noclk;
    x21 |=> !term_rx_clk;
  endproperty
  a_x21_noclk: assert property (p_x21_noclk) else $error("receive clock on x21");

  property p_ll_pin;
    ll_en && pins_s[PIN_LL] |=> lloop_q;
  endproperty
  a_ll_pin: assert property (p_ll_pin) else $error("local loop pin ignored");

  property p_ll_nopin;
    !ll_en && !ll_btn_q && !rose[PIN_BTN_LL] |=> !lloop_q;
  endproperty
  a_ll_nopin: assert property (p_ll_nopin) else $error("local loop without request");

  property p_rl_send;
    rl_q == RL_IDLE && rl_en && pins_s[PIN_RL] |=> rl_q == RL_SEND;
  endproperty
  a_rl_send: assert property (p_rl_send) else $error("remote loop not started");

  property p_delay;
    delay_en && ones_q >= LOOP_DELAY_BITS && rx_tick && !lloop_q |=> !term_rxd;
  endproperty
  a_delay: assert property (p_delay) else $error("loop code passed through");

  property p_err_led;
    pif.err && pat_q ##1 pat_q |-> ##1 led_error;
  endproperty
  a_err_led: assert property (p_err_led) else $error("error indicator dark");

  property p_pat_tx;
    pat_q && tx_tick && !far_q && rl_q != RL_SEND |=> line_txd == $past(pif.tx_bit);
  endproperty
  a_pat_tx: assert property (p_pat_tx) else $error("pattern not on line");

  c_local_loop: cover property (lloop_q && pat_q && pif.in_sync);
  c_remote_up:  cover property (rl_q == RL_SEND ##1 rl_q == RL_ACTIVE);
  c_far_loop:   cover property ($rose(far_q));
  c_pat_err:    cover property (pat_q && pif.err);
endmodule

// ==== design/fmc_pkg.sv ====
// Constants, types and helpers for the fiber modem control block.
// Assumes a 125 MHz clk_sys and an APB master with 32-bit data.
// Functional notes
// - Line rate comes from a twelve-code dial; default code selects 64 kbps.
// - Transmit timing from internal oscillator, terminal clock or line clock.
// - Carrier always on by default, else only while terminal request high.
// - Local loop by pin only when its pin enable is set, else button.
// - Remote loop by pin only when its pin enable is set, else button.
// - Local and remote loops start from a button press or the terminal loop lines; the far loop from a received loop code.
// - Pattern button sends and checks a 511-bit pseudo-random sequence.
// - Error indicator lights or blinks when the checker sees bad bits.
// - Pattern test works in local loop, remote loop or point-to-point.
// - Received data and clock are retimed from the line and delivered clean.
// - Loopbacks follow loop code practice; pattern follows error-rate test practice.
// - Interface variant without receive clock holds that output low.
package fmc_pkg;

  localparam int unsigned CLK_KHZ       = 125000;
  localparam int unsigned BLINK_HALF_MS = 125;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STAT     = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADDR_ERR_CNT  = 8'h10;

  // Control register layout
  localparam int unsigned CTRL_W        = 11;
  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_SRC_LSB  = 4;
  localparam int unsigned CTRL_TX_LIGHT_MODE_FR  = 6;
  localparam int unsigned CTRL_DELAY    = 7;
  localparam int unsigned CTRL_LL_EN    = 8;
  localparam int unsigned CTRL_RL_EN    = 9;
  localparam int unsigned CTRL_X21      = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h009;
  localparam logic [3:0] RATE_DEFAULT      = 4'h9;

  // Interrupt status bits
  localparam int unsigned INT_W        = 4;
  localparam int unsigned INT_ERR      = 0;
  localparam int unsigned INT_SYNC     = 1;
  localparam int unsigned INT_FAR_LOOP = 2;
  localparam int unsigned INT_RL_UP    = 3;

  // Synchronised pin vector positions
  localparam int unsigned PIN_W      = 10;
  localparam int unsigned PIN_TXD    = 0;
  localparam int unsigned PIN_REQ    = 1;
  localparam int unsigned PIN_EXTCLK = 2;
  localparam int unsigned PIN_LL     = 3;
  localparam int unsigned PIN_RL     = 4;
  localparam int unsigned PIN_RXD    = 5;
  localparam int unsigned PIN_RXCLK  = 6;
  localparam int unsigned PIN_BTN_LL = 7;
  localparam int unsigned PIN_BTN_RL = 8;
  localparam int unsigned PIN_PAT    = 9;

  // Bit counts
  localparam logic [9:0] LOOP_CODE_BITS  = 10'h100;
  localparam logic [9:0] LOOP_DET_BITS   = 10'h0c8;
  localparam logic [9:0] LOOP_DELAY_BITS = 10'h064;
  localparam logic [9:0] ERR_STEADY_BITS = 10'h010;
  localparam logic [9:0] ERR_QUIET_BITS  = 10'h200;
  localparam logic [4:0] PRBS_SYNC_BITS  = 5'h12;
  localparam logic [8:0] PRBS_SEED       = 9'h1ff;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_EXT = 2'h1,
    SRC_RCV = 2'h2
  } fmc_clksrc_e;

  typedef enum logic [2:0] {
    RL_IDLE   = 3'b001,
    RL_SEND   = 3'b010,
    RL_ACTIVE = 3'b100
  } fmc_rloop_e;

  // Dial code to kbps
  function automatic logic [12:0] rate_kbps(input logic [3:0] code);
    case (code)
      4'h0:    rate_kbps = 13'd1544;
      4'h1:    rate_kbps = 13'd1536;
      4'h2:    rate_kbps = 13'd768;
      4'h3:    rate_kbps = 13'd384;
      4'h4:    rate_kbps = 13'd2048;
      4'h5:    rate_kbps = 13'd1024;
      4'h6:    rate_kbps = 13'd512;
      4'h7:    rate_kbps = 13'd256;
      4'h8:    rate_kbps = 13'd128;
      4'h9:    rate_kbps = 13'd64;
      4'ha:    rate_kbps = 13'd112;
      4'hb:    rate_kbps = 13'd56;
      default: rate_kbps = 13'd64;
    endcase
  endfunction

  // Feedback of x^9 + x^5 + 1
  function automatic logic prbs_fb(input logic [8:0] s);
    prbs_fb = s[8] ^ s[4];
  endfunction

endpackage

// ==== design/fmc_prbs_if.sv ====
// Bundle between the control core and the pattern engine.
// Both ends run on clk_sys.
`timescale 1ns/1ns
interface fmc_prbs_if;
  logic run;
  logic tx_tick;
  logic tx_bit;
  logic rx_tick;
  logic rx_bit;
  logic err;
  logic in_sync;
  modport core (output run, tx_tick, rx_tick, rx_bit, input tx_bit, err, in_sync);
  modport prbs (input run, tx_tick, rx_tick, rx_bit, output tx_bit, err, in_sync);
endinterface

// ==== design/fmc_sync.sv ====
// Two-flop synchroniser for asynchronous pins.
// Only the second stage may be read by other logic.
`timescale 1ns/1ns
module fmc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== design/fmc_prbs.sv ====
// Pattern generator and self-synchronising checker.
// Advances only on the bit ticks given by the core.
`timescale 1ns/1ns
module fmc_prbs
  import fmc_pkg::*;
(
  input wire logic    clk_sys,
  input wire logic    rstn,
  fmc_prbs_if.prbs    pif
);
  logic [8:0] gen_q, gen_d, chk_q, chk_d;
  logic [4:0] good_q, good_d;
  logic       err_q, err_d;

  always_comb begin
    gen_d  = gen_q;
    chk_d  = chk_q;
    good_d = good_q;
    err_d  = 1'b0;
    if (pif.run && pif.tx_tick) begin
      gen_d = {gen_q[7:0], prbs_fb(gen_q)};
    end
    if (!pif.run) begin
      good_d = '0;
    end else if (pif.rx_tick) begin
      chk_d = {chk_q[7:0], pif.rx_bit};
      if (pif.rx_bit != prbs_fb(chk_q)) begin
        err_d = (good_q == PRBS_SYNC_BITS);
        if (good_q != PRBS_SYNC_BITS) begin
          good_d = '0;
        end
      end else if (good_q != PRBS_SYNC_BITS) begin
        good_d = good_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gen_q  <= PRBS_SEED;
      chk_q  <= '0;
      good_q <= '0;
      err_q  <= 1'b0;
    end else begin
      gen_q  <= gen_d;
      chk_q  <= chk_d;
      good_q <= good_d;
      err_q  <= err_d;
    end
  end

  assign pif.tx_bit  = gen_q[0];
  assign pif.err     = err_q;
  assign pif.in_sync = (good_q == PRBS_SYNC_BITS);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_prbs_poly;
    pif.run && pif.tx_tick |=> gen_q[0] == ($past(gen_q[8]) ^ $past(gen_q[4]));
  endproperty
  a_prbs_poly: assert property (p_prbs_poly) else $error("generator polynomial wrong");

  property p_prbs_err;
    pif.run && pif.rx_tick && pif.in_sync && (pif.rx_bit != prbs_fb(chk_q)) |=> pif.err;
  endproperty
  a_prbs_err: assert property (p_prbs_err) else $error("checker missed a bad bit");

  c_prbs_sync: cover property (pif.run ##1 $rose(pif.in_sync));
endmodule

// ==== bench/fmc_far_unit.sv ====
// Far fiber unit: free-running recovered clock, loops line data back.
// Assumes the bench raises flip for one link bit to corrupt the loop.
`timescale 1ns/1ns
module fmc_far_unit (
  input  wire logic line_txd,
  input  wire logic flip,
  output logic      line_rx_clk,
  output logic      line_rxd
);
  initial begin
    line_rx_clk = 1'b0;
    line_rxd    = 1'b0;
  end
  always #32 line_rx_clk = ~line_rx_clk;
  always @(posedge line_rx_clk) begin
    line_rxd <= line_txd ^ flip;
  end
endmodule

// ==== bench/tb.sv ====
// Bench for fmc_top: APB master, terminal pins, buttons, far unit loop.
// Assumes clk_sys at 125 MHz and a 64 ns line clock from the far unit.
`timescale 1ns/1ns
module tb;
  import fmc_pkg::*;
  logic        clk_sys = 1'b0, rstn = 1'b0, flip = 1'b0, er;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, line_txd, line_rxd, line_rx_clk, tx_light;
  logic        term_req = 1'b0, ll = 1'b0, rl = 1'b0, term_rx_clk;
  logic        txd = 1'b0, term_rxd, term_tx_clk;
  logic [2:0]  bt = 3'h0;
  logic        led_test, led_error, irq;
  int          n_compared = 0, n_mismatch = 0;

  always #4 clk_sys = ~clk_sys;

  fmc_top #(.BLINK_HALF_CYCLES(8)) dut (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .term_txd(txd), .term_req, .term_ext_clk(1'b0), .term_local_loop(ll),
    .term_remote_loop(rl), .line_rxd, .line_rx_clk, .btn_local_loop(bt[0]),
    .btn_remote_loop(bt[1]), .pattern_test_button(bt[2]), .line_txd, .tx_light,
    .term_rxd, .term_tx_clk, .term_rx_clk, .led_test, .led_error, .irq);
  fmc_far_unit far (.line_txd, .flip, .line_rx_clk, .line_rxd);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tmo;
    n_mismatch++;
    conclude();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (k == 20) tmo();
  endtask

  task automatic rdw(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === v) break;
    end
    if (i == n) tmo();
    chk(rd[b], v);
  endtask

  task automatic press(input int i);
    bt[i] <= 1'b1;
    cyc(8);
    bt[i] <= 1'b0;
    cyc(8);
  endtask

  task automatic t_regs;
    int c;
    poll(ADDR_STAT, 7, 1'b1, 1);
    rdw(ADDR_CTRL);
    chk(rd[10:0], 11'h009);
    for (c = 0; c < 12; c++) begin
      wr(ADDR_CTRL, 32'(c));
      rdw(ADDR_CTRL);
      chk(rd, 32'(c));
    end
    poll(8'h14, 0, 1'b0, 1);
    chk(er, 1'b1);
    wr(ADDR_CTRL, 32'h049);
    cyc(8);
    chk(tx_light, 1'b0);
    term_req <= 1'b1;
    cyc(8);
    chk(tx_light, 1'b1);
    $display("test regs and carrier done");
  endtask

  task automatic t_loops;
    wr(ADDR_CTRL, 32'h009);
    ll <= 1'b1;
    cyc(8);
    poll(ADDR_STAT, 0, 1'b0, 1);
    wr(ADDR_CTRL, 32'h109);
    poll(ADDR_STAT, 0, 1'b1, 10);
    chk(led_test, 1'b1);
    ll <= 1'b0;
    poll(ADDR_STAT, 0, 1'b0, 10);
    press(0);
    poll(ADDR_STAT, 0, 1'b1, 10);
    press(0);
    poll(ADDR_STAT, 0, 1'b0, 10);
    wr(ADDR_CTRL, 32'h029);
    rl <= 1'b1;
    cyc(8);
    poll(ADDR_STAT, 1, 1'b0, 1);
    wr(ADDR_CTRL, 32'h229);
    poll(ADDR_STAT, 1, 1'b1, 10);
    cyc(30);
    chk(line_txd, 1'b1);
    poll(ADDR_STAT, 2, 1'b1, 2000);
    rl <= 1'b0;
    poll(ADDR_STAT, 2, 1'b0, 10);
    $display("test loops done");
  endtask

  task automatic t_pat;
    logic [9:0]  h;
    logic [31:0] e0;
    int          i;
    wr(ADDR_CTRL, 32'h029);
    wr(ADDR_INT_MASK, 32'h1);
    press(2);
    poll(ADDR_STAT, 5, 1'b1, 300);
    h = 10'h0;
    for (i = 0; i < 40; i++) begin
      @(posedge line_rx_clk);
      h = {h[8:0], line_txd};
      if (i > 8) chk(h[0], h[9] ^ h[5]);
    end
    @(posedge clk_sys);
    wr(ADDR_INT_STAT, 32'hf);
    rdw(ADDR_ERR_CNT);
    e0 = rd;
    @(posedge line_rx_clk);
    flip <= 1'b1;
    @(posedge line_rx_clk);
    flip <= 1'b0;
    @(posedge clk_sys);
    poll(ADDR_INT_STAT, 0, 1'b1, 100);
    cyc(2);
    chk(irq, 1'b1);
    poll(ADDR_STAT, 6, 1'b1, 100);
    cyc(100);
    rdw(ADDR_ERR_CNT);
    chk(rd, e0 + 32'h3);
    wr(ADDR_INT_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    cyc(4400);
    chk(led_error, 1'b0);
    press(2);
    poll(ADDR_STAT, 4, 1'b0, 10);
    $display("test pattern done");
  endtask

  task automatic t_clk;
    logic s;
    int   i;
    for (i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, i ? 32'h029 : 32'h429);
      cyc(4);
      s = 1'b0;
      repeat (64) begin
        @(posedge clk_sys);
        s = s | term_rx_clk;
      end
      chk(s, i[0]);
    end
    $display("test receive clock done");
  endtask

  // Run of ones from the far side loops the line, then a mid-run reset
  task automatic t_far;
    wr(ADDR_CTRL, 32'h0a9);
    txd <= 1'b1;
    poll(ADDR_STAT, 3, 1'b1, 1000);
    chk(term_rxd, 1'b0);
    txd <= 1'b0;
    cyc(40);
    chk(line_txd, 1'b1);
    rstn <= 1'b0;
    cyc(8);
    rstn <= 1'b1;
    cyc(1);
    rdw(ADDR_CTRL);
    chk(rd, 32'h009);
    poll(ADDR_STAT, 3, 1'b0, 1);
    $display("test far loop done");
  endtask

  // Sixteen internal bit periods at 2048 kbps span 976.56 system cycles
  task automatic t_rate;
    int   c, r, t0;
    logic p;
    wr(ADDR_CTRL, 32'h004);
    cyc(4);
    p  = term_tx_clk;
    r  = 0;
    t0 = 0;
    for (c = 0; c < 2000 && r < 17; c++) begin
      @(posedge clk_sys);
      if (term_tx_clk && !p) begin
        if (r == 0) t0 = c;
        r++;
      end
      p = term_tx_clk;
    end
    chk(((c - 1 - t0) > 975) && ((c - 1 - t0) < 978), 1'b1);
    $display("test rate done");
  endtask

  initial begin
    cyc(8);
    rstn <= 1'b1;
    cyc(1);
    t_regs();
    t_loops();
    t_pat();
    t_clk();
    t_far();
    t_rate();
    conclude();
  end
endmodule
